/* core/pwmc_defines.vh */
// Purpose: constants of the four channel waveform generator
// Assumes: register index times four gives the byte address
// Notes:   definitions only
`ifndef PWMC_DEFINES_VH
`define PWMC_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PWMC_IDX_PRE      10'h040
`define PWMC_IDX_SELPOL   10'h041
`define PWMC_IDX_EN       10'h042
`define PWMC_IDX_PRESC    10'h043
`define PWMC_IDX_SCAL0    10'h044
`define PWMC_IDX_SCNT0    10'h045
`define PWMC_IDX_SCAL1    10'h046
`define PWMC_IDX_SCNT1    10'h047
`define PWMC_IDX_CNT0     10'h048
`define PWMC_IDX_PER0     10'h04c
`define PWMC_IDX_DUTY0    10'h050
`define PWMC_IDX_ALIGN    10'h054

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWMC_JOIN_LO_BIT  6
`define PWMC_DIV_A_LSB    3
`define PWMC_DIV_B_LSB    0
`define PWMC_SEL_LSB      4
`define PWMC_POL_LSB      0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PWMC_PRE_RST      8'h00
`define PWMC_SELPOL_RST   8'h00
`define PWMC_EN_RST       4'h0
`define PWMC_SCAL_RST     8'h00
`define PWMC_ALIGN_RST    4'h0
`define PWMC_CNT_RST      8'h00
`define PWMC_PER_RST      8'hff
`define PWMC_DUTY_RST     8'hff

`endif

/* core/pwmc_prescale.v */
// Purpose: prescale counter making clock A and clock B ticks
// Assumes: clock P is one tick per hclk cycle
// Notes:   counter holds while run is low to save power
`timescale 1ns/1ns
`include "pwmc_defines.vh"

module pwmc_prescale
(
	input  wire       hclk,
	input  wire       hresetn,
	input  wire       run,     // Any channel enabled
	input  wire [2:0] div_a,   // Clock A power of two
	input  wire [2:0] div_b,   // Clock B power of two
	output wire       tick_a,  // One cycle per clock A period
	output wire       tick_b,  // One cycle per clock B period
	output wire [6:0] count    // Prescale counter value
);

	reg [6:0] cnt_reg;  // Counter that advances only while run is high

	// ----------------------------------------
	// Tick decode
	// ----------------------------------------
	// Low n bits all ones marks every 2^n-th P cycle
	function tick_of;
		input [6:0] c;
		input [2:0] n;
		reg   [6:0] mask;
		begin
			mask    = (7'h01 << n) - 7'h01;
			tick_of = ((c & mask) == mask);
		end
	endfunction

	assign tick_a = run & tick_of(cnt_reg, div_a);
	assign tick_b = run & tick_of(cnt_reg, div_b);
	assign count  = cnt_reg;

	// Counter advances once per P cycle only while running
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_reg <= 7'h00;
		else if (run)
			cnt_reg <= cnt_reg + 7'h01;
	end

endmodule

/* core/pwmc_scaler.v */
// Purpose: scaled clock from a prescaled tick
// Assumes: tick_in is a one cycle pulse
// Notes:   divides by (scale + 1) and then by two
`timescale 1ns/1ns
`include "pwmc_defines.vh"

module pwmc_scaler
(
	input  wire       hclk,
	input  wire       hresetn,
	input  wire       tick_in,   // Clock A or B tick
	input  wire [7:0] scale,     // Scale value
	input  wire       load,      // Scale register written
	output wire       tick_out,  // Scaled clock tick
	output wire [7:0] count      // Down counter value
);

	reg [7:0] cnt_reg;   // Down counter
	reg       half_reg;  // Second stage divide by two

	assign tick_out = tick_in & (cnt_reg == 8'h00) & half_reg;
	assign count    = cnt_reg;

	// ----------------------------------------
	// Down counter with reload
	// ----------------------------------------
	// A write reloads at once, from the scale value held before that write
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_reg  <= `PWMC_SCAL_RST;
			half_reg <= 1'b0;
		end
		else if (load)
		begin
			cnt_reg  <= scale;
			half_reg <= 1'b0;
		end
		else if (tick_in)
		begin
			if (cnt_reg == 8'h00)
			begin
				cnt_reg  <= scale;
				half_reg <= ~half_reg;
			end
			else
				cnt_reg <= cnt_reg - 8'h01;
		end
	end

endmodule

/* core/pwmc_top.v */
// Purpose: four channel waveform generator with AHB-Lite registers
// Assumes: single slave, hready tied to own hreadyout
// Notes:   zero wait state, always OKAY
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "pwmc_defines.vh"

module pwmc_top
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [11:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire [3:0]  gpio_out,
	input  wire [3:0]  gpio_drive,
	output reg  [3:0]  pin_out,
	output reg  [3:0]  pin_oe_n
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [7:0] prescale_pairing_reg;        // Join bits and dividers
	reg [7:0] clock_select_polarity_reg;   // Sources and start levels
	reg [3:0] channel_enable_bits_reg;     // Channel enables
	reg [7:0] scaled_divider_zero_reg;     // Scale for S0
	reg [7:0] scaled_divider_one_reg;      // Scale for S1
	reg [3:0] align_center_reg;            // One per channel, 1 = center
	reg [7:0] per_buf_reg  [0:3];          // Buffered period
	reg [7:0] duty_buf_reg [0:3];          // Buffered duty
	reg [7:0] per_act_reg  [0:3];          // Active period
	reg [7:0] duty_act_reg [0:3];          // Active duty
	reg [7:0] channel_counter_reg [0:3];   // Channel counters
	reg [3:0] dir_down_reg;                // Center mode direction

	// Bus data phase state
	reg       wr_reg;        // Write pending in data phase
	reg [9:0] wr_idx_reg;    // Its register index
	reg [31:0] rd_next;      // Read mux

	integer i;   // Loop index of the buffer and counter process
	integer j;   // Loop index of the read mux
	integer k;   // Loop index of the pin process

	// ----------------------------------------
	// Bus address phase decode
	// ----------------------------------------
	wire       take    = hsel & htrans[1] & hready;
	wire [9:0] a_idx   = haddr[11:2];

	// Write strobe for one register index
	function hit;
		input [9:0] a;
		begin
			hit = wr_reg & (wr_idx_reg == a);
		end
	endfunction

	// ----------------------------------------
	// Clock tree
	// ----------------------------------------
	wire       tick_a;
	wire       tick_b;
	wire       tick_s0;
	wire       tick_s1;
	wire [6:0] pre_count;
	wire [7:0] scnt0;
	wire [7:0] scnt1;

	// P is hclk itself; counter stops when no channel runs
	pwmc_prescale u_pre
	(
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (|channel_enable_bits_reg),
		.div_a   (prescale_pairing_reg[`PWMC_DIV_A_LSB+2:`PWMC_DIV_A_LSB]),
		.div_b   (prescale_pairing_reg[`PWMC_DIV_B_LSB+2:`PWMC_DIV_B_LSB]),
		.tick_a  (tick_a),
		.tick_b  (tick_b),
		.count   (pre_count)
	);

	// S0 from clock A
	pwmc_scaler u_s0
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.tick_in  (tick_a),
		.scale    (scaled_divider_zero_reg),
		.load     (hit(`PWMC_IDX_SCAL0)),
		.tick_out (tick_s0),
		.count    (scnt0)
	);

	// S1 from clock B
	pwmc_scaler u_s1
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.tick_in  (tick_b),
		.scale    (scaled_divider_one_reg),
		.load     (hit(`PWMC_IDX_SCAL1)),
		.tick_out (tick_s1),
		.count    (scnt1)
	);

	// ----------------------------------------
	// Per channel datapath
	// ----------------------------------------
	wire [3:0] src_tick;   // Selected counting tick per channel
	wire [3:0] tk;         // Unit advances this cycle
	wire [3:0] roll;       // Unit period ends this cycle
	wire [3:0] dir_n;      // Next direction of unit
	wire [3:0] lvl;        // Waveform level of unit
	wire [3:0] idle;       // Low byte of a joined pair
	wire [3:0] en_e;       // Effective enable
	wire [3:0] cw;         // Counter write hits channel
	wire [3:0] ld;         // Active latch loads this cycle
	wire [7:0] cnt_n  [0:3];  // Next counter byte
	wire [7:0] per_n  [0:3];  // Buffer value incl. write
	wire [7:0] duty_n [0:3];
	wire [15:0] nxt_w [0:3];  // Unit next count

	genvar c;
	generate
		for (c = 0; c < 4; c = c + 1)
		begin : g_ch
			localparam H = (c / 2) * 2;
			localparam L = H + 1;
			localparam P = c / 2;

			wire joined = prescale_pairing_reg[`PWMC_JOIN_LO_BIT + P];
			wire wide = joined & (c == H);
			wire sel  = clock_select_polarity_reg[`PWMC_SEL_LSB + c];
			wire pol  = clock_select_polarity_reg[`PWMC_POL_LSB + c];
			wire ctr  = align_center_reg[c];
			wire [15:0] cur;
			wire [15:0] per;
			wire [15:0] dut;
			reg  [15:0] nxt;
			reg         rl;
			reg         dn;

			// A/S0 for 0,1; B/S1 for 2,3; a change lands on next tick
			if (c < 2)
			begin : g_ab
				assign src_tick[c] = sel ? tick_s0 : tick_a;
			end
			else
			begin : g_b
				assign src_tick[c] = sel ? tick_s1 : tick_b;
			end

			assign idle[c] = joined & (c == L);
			assign en_e[c] = channel_enable_bits_reg[idle[c] ? H : c];
			// Joined pair counts on the low channel's clock
			assign tk[c] = en_e[c] & ~idle[c] & src_tick[wide ? L : c];

			// Joined: high byte from H, low byte from L
			assign cur = wide ? {channel_counter_reg[H], channel_counter_reg[L]}
				: {8'h00, channel_counter_reg[c]};
			assign per = wide ? {per_act_reg[H], per_act_reg[L]}
				: {8'h00, per_act_reg[c]};
			assign dut = wide ? {duty_act_reg[H], duty_act_reg[L]}
				: {8'h00, duty_act_reg[c]};

			// Next count, direction and period end
			always @*
			begin
				nxt = cur + 16'h0001;
				rl  = 1'b0;
				dn  = dir_down_reg[c];
				if (!ctr)
				begin
					dn = 1'b0;
					if (nxt >= per)
					begin
						nxt = 16'h0000;
						rl  = 1'b1;
					end
				end
				else if (!dir_down_reg[c])
				begin
					if (nxt >= per)
						dn = 1'b1;
				end
				else
				begin
					nxt = cur - 16'h0001;
					if (nxt == 16'h0000)
					begin
						dn = 1'b0;
						rl = 1'b1;
					end
				end
			end

			assign nxt_w[c] = nxt;
			assign roll[c]  = rl;
			assign dir_n[c] = dn;
			// Below duty: start level; polarity ignored when centered
			assign lvl[c] = ctr ? (cur < dut)
				: ((cur < dut) ? pol : ~pol);

			// Byte this channel's counter takes when its unit steps
			if (c == L)
			begin : g_lo
				assign cnt_n[c] = idle[c] ? nxt_w[H][7:0] : nxt_w[c][7:0];
				// Either byte write resets a joined counter
				assign cw[c] = hit(`PWMC_IDX_CNT0 + c)
					| (joined & hit(`PWMC_IDX_CNT0 + H));
				assign ld[c] = ~en_e[c] | cw[c]
					| (idle[c] ? (tk[H] & roll[H]) : (tk[c] & roll[c]));
			end
			else
			begin : g_hi
				assign cnt_n[c] = wide ? nxt_w[c][15:8] : nxt_w[c][7:0];
				assign cw[c] = hit(`PWMC_IDX_CNT0 + c)
					| (joined & hit(`PWMC_IDX_CNT0 + L));
				assign ld[c] = ~en_e[c] | cw[c] | (tk[c] & roll[c]);
			end

			// Buffer value with any write of this cycle folded in
			assign per_n[c]  = hit(`PWMC_IDX_PER0 + c) ? hwdata[7:0] : per_buf_reg[c];
			assign duty_n[c] = hit(`PWMC_IDX_DUTY0 + c) ? hwdata[7:0] : duty_buf_reg[c];
		end
	endgenerate

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// Writable at any time, no restriction
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prescale_pairing_reg      <= `PWMC_PRE_RST;
			clock_select_polarity_reg <= `PWMC_SELPOL_RST;
			channel_enable_bits_reg   <= `PWMC_EN_RST;
			scaled_divider_zero_reg   <= `PWMC_SCAL_RST;
			scaled_divider_one_reg    <= `PWMC_SCAL_RST;
			align_center_reg          <= `PWMC_ALIGN_RST;
		end
		else
		begin
			if (hit(`PWMC_IDX_PRE))
				prescale_pairing_reg <= hwdata[7:0];
			if (hit(`PWMC_IDX_SELPOL))
				clock_select_polarity_reg <= hwdata[7:0];
			if (hit(`PWMC_IDX_EN))
				channel_enable_bits_reg <= hwdata[3:0];
			if (hit(`PWMC_IDX_SCAL0))
				scaled_divider_zero_reg <= hwdata[7:0];
			if (hit(`PWMC_IDX_SCAL1))
				scaled_divider_one_reg <= hwdata[7:0];
			if (hit(`PWMC_IDX_ALIGN))
				align_center_reg <= hwdata[3:0];
		end
	end

	// ----------------------------------------
	// Buffers, active latches and counters
	// ----------------------------------------
	// Counters keep their value when a channel is disabled
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dir_down_reg <= 4'h0;
			for (i = 0; i < 4; i = i + 1)
			begin
				per_buf_reg[i]         <= `PWMC_PER_RST;
				duty_buf_reg[i]        <= `PWMC_DUTY_RST;
				per_act_reg[i]         <= `PWMC_PER_RST;
				duty_act_reg[i]        <= `PWMC_DUTY_RST;
				channel_counter_reg[i] <= `PWMC_CNT_RST;
			end
		end
		else
		begin
			for (i = 0; i < 4; i = i + 1)
			begin
				per_buf_reg[i]  <= per_n[i];
				duty_buf_reg[i] <= duty_n[i];
				if (ld[i])
				begin
					per_act_reg[i]  <= per_n[i];
					duty_act_reg[i] <= duty_n[i];
				end
				if (cw[i])
				begin
					channel_counter_reg[i] <= `PWMC_CNT_RST;
					dir_down_reg[i]        <= 1'b0;
				end
				else if (idle[i] ? tk[i & 2] : tk[i])
				begin
					channel_counter_reg[i] <= cnt_n[i];
					dir_down_reg[i]        <= dir_n[i];
				end
			end
		end
	end

	// ----------------------------------------
	// Pin multiplexing
	// ----------------------------------------
	// Enabled channel owns its pin; joined low pin goes back to port
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_out  <= 4'h0;
			pin_oe_n <= 4'hf;
		end
		else
		begin
			for (k = 0; k < 4; k = k + 1)
			begin
				if (en_e[k] & ~idle[k])
				begin
					pin_out[k]  <= lvl[k];
					pin_oe_n[k] <= 1'b0;
				end
				else
				begin
					pin_out[k]  <= gpio_out[k];
					pin_oe_n[k] <= ~gpio_drive[k];
				end
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Unmapped indices read as zero
	always @*
	begin
		rd_next = 32'h0000_0000;
		case (a_idx)
			`PWMC_IDX_PRE:    rd_next[7:0] = prescale_pairing_reg;
			`PWMC_IDX_SELPOL: rd_next[7:0] = clock_select_polarity_reg;
			`PWMC_IDX_EN:     rd_next[3:0] = channel_enable_bits_reg;
			`PWMC_IDX_PRESC:  rd_next[6:0] = pre_count;
			`PWMC_IDX_SCAL0:  rd_next[7:0] = scaled_divider_zero_reg;
			`PWMC_IDX_SCNT0:  rd_next[7:0] = scnt0;
			`PWMC_IDX_SCAL1:  rd_next[7:0] = scaled_divider_one_reg;
			`PWMC_IDX_SCNT1:  rd_next[7:0] = scnt1;
			`PWMC_IDX_ALIGN:  rd_next[3:0] = align_center_reg;
			default:          rd_next = 32'h0000_0000;
		endcase
		for (j = 0; j < 4; j = j + 1)
		begin
			if (a_idx == `PWMC_IDX_CNT0 + j)
				rd_next[7:0] = channel_counter_reg[j];
			if (a_idx == `PWMC_IDX_PER0 + j)
				rd_next[7:0] = per_buf_reg[j];
			if (a_idx == `PWMC_IDX_DUTY0 + j)
				rd_next[7:0] = duty_buf_reg[j];
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// Zero wait: read data sampled at the address phase edge
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_reg     <= 1'b0;
			wr_idx_reg <= 10'h000;
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
		else
		begin
			wr_reg     <= take & hwrite;
			wr_idx_reg <= a_idx;
			hrdata     <= (take & ~hwrite) ? rd_next : 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
	end

endmodule

/* dv/pwmc_load.sv */
// Purpose: external load on the four port pins
// Assumes: weak pull-down on every pin
// Notes:   a released pin reads the pull level
`timescale 1ns/1ns

module pwmc_load
(
	input  wire [3:0] pin_out,
	input  wire [3:0] pin_oe_n,
	output wire [3:0] pin_lvl
);
// ------------
// Wire level
// ------------
// Pull-down wins only where nobody drives the pin
assign pin_lvl = pin_out & ~pin_oe_n;
endmodule

/* dv/pwmc_top_properties.sv */
// Purpose: port checks of the waveform generator
// Assumes: single word transfers that never overlap
// Notes:   config registers shadowed from bus writes
`timescale 1ns/1ns
`include "pwmc_defines.vh"

module pwmc_props
(
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [11:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire [3:0]  gpio_out,
	input wire [3:0]  gpio_drive,
	input wire [3:0]  pin_out,
	input wire [3:0]  pin_oe_n
);
// ------------
// Shadow state
// ------------
reg  [9:0] idx_reg;   // Index of data phase
reg        wr_reg;    // Write data phase
reg        rd_reg;    // Read data phase
reg  [7:0] pre_reg;   // Divide and pairing
reg  [7:0] sp_reg;    // Select and polarity
reg  [3:0] en_reg;    // Channel enables
reg  [7:0] pc_reg;    // Last prescale count read
reg        pc_ok_reg; // Count known and frozen
reg        up_reg;    // Pins meaningful
wire       take = hsel & htrans[1] & hready;
wire [3:0] own = en_reg & ~{pre_reg[7], 1'b0, pre_reg[6], 1'b0};
// Follow bus phases; pins lag reset by one edge
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		idx_reg <= 10'h000;
		wr_reg <= 1'b0;
		rd_reg <= 1'b0;
		pre_reg <= 8'h00;
		sp_reg <= 8'h00;
		en_reg <= 4'h0;
		pc_reg <= 8'h00;
		pc_ok_reg <= 1'b0;
		up_reg <= 1'b0;
	end
	else
	begin
		up_reg <= 1'b1;
		idx_reg <= haddr[11:2];
		wr_reg <= take & hwrite;
		rd_reg <= take & ~hwrite;
		if (wr_reg && idx_reg == `PWMC_IDX_PRE)
			pre_reg <= hwdata[7:0];
		if (wr_reg && idx_reg == `PWMC_IDX_SELPOL)
			sp_reg <= hwdata[7:0];
		if (wr_reg && idx_reg == `PWMC_IDX_EN)
			en_reg <= hwdata[3:0];
		if (rd_reg && idx_reg == `PWMC_IDX_PRESC)
			pc_reg <= hrdata[7:0];
		// Any enable lets the count run on, so forget it
		pc_ok_reg <= (en_reg == 4'h0) & (pc_ok_reg | (rd_reg && idx_reg == `PWMC_IDX_PRESC));
	end
end
// ------------
// Assertions
// ------------
default clocking dcb @(posedge hclk); endclocking
default disable iff (!hresetn);
a_idle_dir: assert property (up_reg |-> ((pin_oe_n ^ ~$past(gpio_drive)) & ~$past(en_reg)) == 4'h0)
	else $error("idle pin direction not from port");
a_idle_data: assert property (up_reg |-> ((pin_out ^ $past(gpio_out)) & ~$past(own)) == 4'h0)
	else $error("idle pin level not from port");
a_owned_drives: assert property (up_reg |-> (pin_oe_n & $past(own)) == 4'h0)
	else $error("enabled channel pin not driven");
a_join_low: assert property (up_reg && $past(pre_reg[6]) |-> pin_oe_n[1] == !$past(gpio_drive[1]))
	else $error("joined low pin not released");
a_join_high: assert property (up_reg && $past(pre_reg[7]) |-> pin_oe_n[3] == !$past(gpio_drive[3]))
	else $error("joined upper low pin not released");
a_zero_wait: assert property (hreadyout)
	else $error("wait state inserted");
a_okay_resp: assert property (!hresp)
	else $error("error response");
a_pre_read: assert property (rd_reg && idx_reg == `PWMC_IDX_PRE |-> hrdata == {24'h0, pre_reg})
	else $error("divide register read wrong");
a_sel_read: assert property (rd_reg && idx_reg == `PWMC_IDX_SELPOL |-> hrdata == {24'h0, sp_reg})
	else $error("select register read wrong");
a_count_frozen: assert property (rd_reg && idx_reg == `PWMC_IDX_PRESC && pc_ok_reg |-> hrdata == {24'h0, pc_reg})
	else $error("prescaler ran with all channels off");
c_enable: cover property (wr_reg && idx_reg == `PWMC_IDX_EN && hwdata[3:0] != 4'h0);
c_joined: cover property (pre_reg[7] && en_reg[2]);
c_frozen: cover property (pc_ok_reg && rd_reg);
endmodule

bind pwmc_top pwmc_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gpio_out(gpio_out),
	.gpio_drive(gpio_drive), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

/* dv/four_channel_pwm_clocking_bench.sv */
// Purpose: self-checking bench of the waveform generator
// Assumes: zero wait AHB-Lite slave, clock P equals hclk
// Notes:   waveforms judged by high time and rises in 128 cycles
`timescale 1ns/1ns
`include "pwmc_defines.vh"

module four_channel_pwm_clocking_bench;
// ------------
// Signals and tables
// ------------
typedef struct {int ch; logic [7:0] pre; logic [7:0] sp; logic [7:0] sc;
	logic [15:0] per; logic [15:0] dut; int hi; int ri;} pwmc_row_t;
reg         hclk;
reg         hresetn;
reg         hsel;
reg  [11:0] haddr;
reg  [1:0]  htrans;
reg         hwrite;
reg  [2:0]  hsize;
reg  [31:0] hwdata;
reg  [3:0]  gpio_out;
reg  [3:0]  gpio_drive;
wire [31:0] hrdata;
wire        hreadyout;
wire        hresp;
wire [3:0]  pin_out;
wire [3:0]  pin_oe_n;
wire [3:0]  pin_lvl;
int         miscompares = 0;
int         check_count = 0;
// Channel, divide, select, scale, period, duty, high, rises
pwmc_row_t  rows [12] = '{
	'{0, 8'h00, 8'h01, 8'h00, 16'h0004, 16'h0001, 32, 32},
	'{0, 8'h00, 8'h00, 8'h00, 16'h0004, 16'h0001, 96, 32},
	'{0, 8'h00, 8'h01, 8'h00, 16'h0004, 16'h0000, 0, 0},
	'{0, 8'h00, 8'h01, 8'h00, 16'h0004, 16'h0004, 128, 0},
	'{0, 8'h10, 8'h01, 8'h00, 16'h0004, 16'h0001, 32, 8},
	'{1, 8'h08, 8'h02, 8'h00, 16'h0004, 16'h0001, 32, 16},
	'{1, 8'h00, 8'h22, 8'h01, 16'h0004, 16'h0001, 32, 8},
	'{2, 8'h01, 8'h04, 8'h00, 16'h0004, 16'h0001, 32, 16},
	'{3, 8'h00, 8'h88, 8'h01, 16'h0004, 16'h0001, 32, 8},
	'{3, 8'h00, 8'h00, 8'h00, 16'h0004, 16'h0003, 32, 32},
	'{0, 8'h40, 8'h01, 8'h00, 16'h0004, 16'h0001, 32, 32},
	'{2, 8'h80, 8'h84, 8'h00, 16'h0004, 16'h0001, 32, 16}};
logic [9:0] ridx [10] = '{`PWMC_IDX_PRE, `PWMC_IDX_SELPOL, `PWMC_IDX_EN, `PWMC_IDX_PRESC,
	`PWMC_IDX_SCAL0, `PWMC_IDX_SCNT0, `PWMC_IDX_CNT0, `PWMC_IDX_PER0, `PWMC_IDX_DUTY0, 10'h060};
logic [7:0] rval [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};

pwmc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .gpio_out(gpio_out), .gpio_drive(gpio_drive),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n));
pwmc_load u_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_lvl(pin_lvl));

// Free running bus clock
always #20 hclk = ~hclk;
// ------------
// Tasks
// ------------
// One single transfer; both phases held until ready
task xfer(input logic w, input logic [9:0] i, input logic [31:0] d, output logic [31:0] q);
	@(posedge hclk);
	hsel <= 1'b1;
	haddr <= {i, 2'b00};
	hwrite <= w;
	htrans <= 2'b10;
	@(posedge hclk);
	while (hreadyout !== 1'b1)
		@(posedge hclk);
	hsel <= 1'b0;
	htrans <= 2'b00;
	hwdata <= d;
	@(posedge hclk);
	while (hreadyout !== 1'b1)
		@(posedge hclk);
	q = hrdata;
endtask
task wr(input logic [9:0] i, input logic [7:0] d);
	logic [31:0] q;
	xfer(1'b1, i, {24'h0, d}, q);
endtask
task chk(input string n, input logic [31:0] e, input logic [31:0] s);
	check_count++;
	if (s !== e)
	begin
		miscompares++;
		$display("Error %s expected %h seen %h", n, e, s);
	end
endtask
task rd(input string n, input logic [9:0] i, input logic [31:0] e);
	logic [31:0] q;
	xfer(1'b0, i, 32'h0, q);
	chk(n, e, q);
endtask
// Program a channel while off, so writes land at once
task setup(input pwmc_row_t r, input logic [7:0] al);
	int jn;
	int lo;
	int hc;
	jn = (r.ch == 0 && r.pre[6]) || (r.ch == 2 && r.pre[7]);
	lo = jn ? r.ch + 1 : r.ch;
	hc = jn ? r.ch : r.ch ^ 1;
	wr(`PWMC_IDX_EN, 8'h00);
	wr(`PWMC_IDX_PRE, r.pre);
	wr(`PWMC_IDX_SELPOL, r.sp);
	wr(`PWMC_IDX_SCAL0, r.sc);
	wr(`PWMC_IDX_SCAL1, r.sc);
	wr(`PWMC_IDX_ALIGN, al);
	wr(`PWMC_IDX_PER0 + 10'(lo), r.per[7:0]);
	wr(`PWMC_IDX_PER0 + 10'(hc), r.per[15:8]);
	wr(`PWMC_IDX_DUTY0 + 10'(lo), r.dut[7:0]);
	wr(`PWMC_IDX_DUTY0 + 10'(hc), r.dut[15:8]);
	wr(`PWMC_IDX_CNT0 + 10'(r.ch), 8'h00);
	wr(`PWMC_IDX_EN, 8'(1 << r.ch));
	repeat (8) @(posedge hclk);
endtask
// High cycles and rising edges seen at the load
task meas(input int c, output int hi, output int ri);
	logic p;
	hi = 0;
	ri = 0;
	p = pin_lvl[c];
	repeat (128)
	begin
		@(posedge hclk);
		hi += pin_lvl[c];
		ri += pin_lvl[c] & ~p;
		p = pin_lvl[c];
	end
endtask
task summarize;
	if (miscompares == 0 && check_count > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
// ------------
// Sequence
// ------------
// Hang guard, well past the expected run length
initial
begin
	repeat (8000) @(posedge hclk);
	miscompares++;
	summarize();
end
// Table cases, then center mode, buffering and reset
initial
begin
	int hi;
	int ri;
	int h2;
	logic [31:0] q;
	hclk = 1'b0;
	hresetn = 1'b0;
	hsel = 1'b0;
	haddr = 12'h000;
	htrans = 2'b00;
	hwrite = 1'b0;
	hsize = 3'b010;
	hwdata = 32'h0;
	gpio_out = 4'h0;
	gpio_drive = 4'h0;
	repeat (5) @(posedge hclk);
	hresetn <= 1'b1;
	for (int i = 0; i < 12; i++)
	begin
		gpio_out <= 4'(i);
		gpio_drive <= ~4'(i);
		setup(rows[i], 8'h00);
		meas(rows[i].ch, hi, ri);
		chk("high time", rows[i].hi, hi);
		chk("rise count", rows[i].ri, ri);
	end
	// Center mode: polarity must not matter
	setup(rows[0], 8'h01);
	meas(0, hi, ri);
	chk("center rises", 16, ri);
	chk("center high", 16, hi);
	setup(rows[1], 8'h01);
	meas(0, h2, ri);
	chk("center polarity", 16, h2);
	// Slow period, new values written while running
	setup('{0, 8'h00, 8'h01, 8'h00, 16'h00ff, 16'h00f0, 0, 0}, 8'h00);
	wr(`PWMC_IDX_DUTY0, 8'h01);
	wr(`PWMC_IDX_PER0, 8'h04);
	meas(0, hi, ri);
	chk("held duty", 128, hi);
	wr(`PWMC_IDX_CNT0, 8'h5a);
	// Pin still shows the old level one cycle after the reset
	@(posedge hclk);
	meas(0, hi, ri);
	chk("forced duty", 32, hi);
	xfer(1'b0, `PWMC_IDX_CNT0, 32'h0, q);
	chk("counter range", 1, q < 4);
	// Second reset in mid-run
	gpio_out <= 4'h5;
	gpio_drive <= 4'h3;
	@(posedge hclk);
	hresetn <= 1'b0;
	repeat (2) @(posedge hclk);
	chk("oe in reset", 4'hf, pin_oe_n);
	hresetn <= 1'b1;
	for (int i = 0; i < 10; i++)
		rd("reset value", ridx[i], {24'h0, rval[i]});
	chk("port direction", 4'hc, pin_oe_n);
	chk("port data", 4'h5, pin_out);
	wr(`PWMC_IDX_PRE, 8'ha5);
	wr(`PWMC_IDX_SELPOL, 8'h5a);
	wr(`PWMC_IDX_PRESC, 8'h7f);
	wr(10'h060, 8'hff);
	rd("divide reg", `PWMC_IDX_PRE, 32'ha5);
	rd("select reg", `PWMC_IDX_SELPOL, 32'h5a);
	rd("stopped prescaler", `PWMC_IDX_PRESC, 32'h0);
	rd("unmapped", 10'h060, 32'h0);
	summarize();
end
endmodule
